// [common/mbx_pkg.sv]
// Purpose: shared constants for the mailbox bypass and loopback link
// Assumes: one clock for both ends
// Notes:   host register map is software facing, device has no map
package mbx_pkg;
  localparam int A_W  = 36;
  localparam int BC_W = 18;
  localparam int AW   = 8;
  localparam int DW   = 32;

  // flag reset level, both boxes empty
  localparam logic FULL_N_RST = 1'b1;

  // host register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DATA_LO = 8'h04;
  localparam logic [7:0] OFS_DATA_HI = 8'h08;
  localparam logic [7:0] OFS_CMD     = 8'h0C;
  localparam logic [7:0] OFS_FLAGS   = 8'h10;
  localparam logic [7:0] OFS_ARD_LO  = 8'h14;
  localparam logic [7:0] OFS_ARD_HI  = 8'h18;
  localparam logic [7:0] OFS_BRD     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h24;

  // control bits
  localparam int CTRL_LOOP = 0;
  localparam int CTRL_MRS  = 1;
  localparam int CTRL_QUEUE_ONE_PARTIAL_RESET_N = 2;
  localparam int CTRL_QUEUE_TWO_PARTIAL_RESET_N = 3;

  // command field: op in [2:0], box select in bit 3
  localparam int CMD_BOX = 3;

  // interrupt bits
  localparam int IRQ_N    = 3;
  localparam int IRQ_MB1  = 0;
  localparam int IRQ_MB2  = 1;
  localparam int IRQ_RDAT = 2;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_A_WR,
    OP_A_RD,
    OP_B_RD,
    OP_C_WR
  } op_t;
endpackage

// [common/mbx_link_if.sv]
// Purpose: pins between the queue device and its controller
// Assumes: port A bus resolved here from the two output enables
// Notes:   an undriven port A bus reads as zero
`timescale 1ns/100ps
interface mbx_link_if;
  // port A
  logic                    port_a_transfer_gate;
  logic                    a_write;
  logic                    port_a_box_select;
  logic                    loop_sel_n;
  logic [mbx_pkg::A_W-1:0] a_dev_data;
  logic                    a_dev_oe;
  logic [mbx_pkg::A_W-1:0] a_host_data;
  logic                    a_host_oe;
  logic [mbx_pkg::A_W-1:0] port_a_bus;
  // port B
  logic                     b_read;
  logic                     port_b_box_select;
  logic [mbx_pkg::BC_W-1:0] port_b_bus;
  logic                     b_oe;
  // port C
  logic                     c_write;
  logic                     port_c_box_select;
  logic [mbx_pkg::BC_W-1:0] c_data;
  // flags and resets
  logic box_one_full_n;
  logic box_two_full_n;
  logic queue_one_master_reset_n;
  logic queue_two_master_reset_n;
  logic queue_one_partial_reset_n;
  logic queue_two_partial_reset_n;

  assign port_a_bus = a_dev_oe ? a_dev_data : (a_host_oe ? a_host_data : '0);

  modport dev (
    input  port_a_transfer_gate, a_write, port_a_box_select, loop_sel_n, port_a_bus,
    output a_dev_data, a_dev_oe,
    input  b_read, port_b_box_select,
    output port_b_bus, b_oe,
    input  c_write, port_c_box_select, c_data,
    output box_one_full_n, box_two_full_n,
    input  queue_one_master_reset_n, queue_two_master_reset_n,
    input  queue_one_partial_reset_n, queue_two_partial_reset_n
  );

  modport host (
    output port_a_transfer_gate, a_write, port_a_box_select, loop_sel_n,
    output a_host_data, a_host_oe,
    input  port_a_bus,
    output b_read, port_b_box_select,
    input  port_b_bus, b_oe,
    output c_write, port_c_box_select, c_data,
    input  box_one_full_n, box_two_full_n,
    output queue_one_master_reset_n, queue_two_master_reset_n,
    output queue_one_partial_reset_n, queue_two_partial_reset_n
  );
endinterface

// [hdl/mbx_device.sv]
// Purpose: mailbox bypass and port A loopback steering of a three port queue device
// Assumes: queue memories sit outside, reached on the user side ports
// Notes:   bus outputs and flags are registered, read data appear one cycle late
// Notes on behaviour
// [RL1] loopback moves queue 2 output into queue 1
// [RL2] controller starts loopback: select low, gate high
// [RL3] port A box select picks a mailbox
// [RL4] port A shows mailbox two or queue 2
// [RL5] port B box select reads mailbox one
// [RL6] port B shows mailbox one or queue 1
// [RL7] port C box select writes mailbox two
// [RL8] port C box select high during master reset
// [RL9] port A box write drops flag one low
// [RL10] writes to mailbox one ignored while full
// [RL11] port B box read raises flag one
// [RL12] queue 1 resets raise flag one
// [RL13] port C box write drops flag two low
// [RL14] writes to mailbox two ignored while full
// [RL15] port A box read raises flag two
// [RL16] queue 2 resets raise flag two
// [RL17] port A box write keeps low 18 bits
// [RL18] mailbox reads never alter contents
`timescale 1ns/100ps
module mbx_device (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  // link
  mbx_link_if.dev                        link,
  // queue 1 side
  output logic                           q1_wr_o,
  output logic [mbx_pkg::A_W-1:0]        q1_wdata_o,
  output logic                           q1_rd_o,
  input  wire logic [mbx_pkg::BC_W-1:0]  q1_rdata_i,
  output logic                           q1_clear_o,
  // queue 2 side
  output logic                           q2_wr_o,
  output logic [mbx_pkg::BC_W-1:0]       q2_wdata_o,
  output logic                           q2_rd_o,
  input  wire logic [mbx_pkg::A_W-1:0]   q2_rdata_i,
  output logic                           q2_clear_o,
  // status
  output logic                           loop_active_o
);

  // all device state in one register
  typedef struct packed {
    logic [mbx_pkg::BC_W-1:0] mail1;
    logic [mbx_pkg::BC_W-1:0] mail2;
    logic                     full1_n;
    logic                     full2_n;
    logic [mbx_pkg::A_W-1:0]  a_out;
    logic                     a_oe;
    logic [mbx_pkg::BC_W-1:0] b_out;
    logic                     b_oe;
    logic                     q1_wr;
    logic [mbx_pkg::A_W-1:0]  q1_wdata;
    logic                     q1_rd;
    logic                     q1_clr;
    logic                     q2_wr;
    logic [mbx_pkg::BC_W-1:0] q2_wdata;
    logic                     q2_rd;
    logic                     q2_clr;
    logic                     loop_act;
  } dev_st_t;

  dev_st_t st_ff;
  dev_st_t nxt_st;

  // decoded link requests
  logic loop_on;
  logic a_rd;
  logic a_wr;
  logic q1_rst;
  logic q2_rst;

  // either reset pin of a queue forces its flag
  function automatic logic queue_reset(input logic master_n, input logic partial_n);
    return !master_n || !partial_n;
  endfunction

  // the controller owns the loopback entry condition
  assign loop_on = !link.loop_sel_n && link.port_a_transfer_gate;  // [RL2]
  // a gated cycle with loopback selected is no port A access
  assign a_wr    = link.port_a_transfer_gate && link.a_write && !loop_on;
  assign a_rd    = link.port_a_transfer_gate && !link.a_write && !loop_on;
  assign q1_rst  = queue_reset(link.queue_one_master_reset_n, link.queue_one_partial_reset_n);
  assign q2_rst  = queue_reset(link.queue_two_master_reset_n, link.queue_two_partial_reset_n);

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.q1_wr    = 1'b0;
    nxt_st.q1_rd    = 1'b0;
    nxt_st.q2_wr    = 1'b0;
    nxt_st.q2_rd    = 1'b0;
    nxt_st.loop_act = loop_on;
    nxt_st.a_oe     = a_rd;
    nxt_st.b_oe     = link.b_read;
    nxt_st.q1_clr   = q1_rst;
    nxt_st.q2_clr   = q2_rst;

    // loopback keeps port A off the bus and feeds queue 1 from queue 2
    // one word per cycle, the queue side must keep pace
    if (loop_on) begin
      nxt_st.q2_rd    = 1'b1;  // [RL1]
      nxt_st.q1_wr    = 1'b1;  // [RL1]
      nxt_st.q1_wdata = q2_rdata_i;  // [RL1]
    end

    // reads come first so that a write to an empty box in the same cycle wins the flag; a write to a full box is dropped and the read raises it
    if (a_rd) begin
      if (link.port_a_box_select) begin  // [RL3]
        // box is as wide as port B, upper bits zero
        nxt_st.a_out   = {{(mbx_pkg::A_W-mbx_pkg::BC_W){1'b0}}, st_ff.mail2};  // [RL4] [RL18]
        nxt_st.full2_n = 1'b1;  // [RL15]
      end else begin
        nxt_st.a_out = q2_rdata_i;  // [RL4]
        nxt_st.q2_rd = 1'b1;
      end
    end

    if (link.b_read) begin
      if (link.port_b_box_select) begin  // [RL5]
        // queue 1 is not consumed
        nxt_st.b_out   = st_ff.mail1;  // [RL6] [RL18]
        nxt_st.full1_n = 1'b1;  // [RL11]
      end else begin
        nxt_st.b_out = q1_rdata_i;  // [RL6]
        nxt_st.q1_rd = 1'b1;
      end
    end

    if (a_wr) begin
      if (link.port_a_box_select) begin  // [RL3]
        // a full box keeps its word, the late write is simply lost
        if (st_ff.full1_n) begin  // [RL10]
          nxt_st.mail1   = link.port_a_bus[mbx_pkg::BC_W-1:0];  // [RL17]
          nxt_st.full1_n = 1'b0;  // [RL9]
        end
      end else begin
        nxt_st.q1_wr    = 1'b1;
        // queue 1 takes all 36 bits
        nxt_st.q1_wdata = link.port_a_bus;
      end
    end

    if (link.c_write) begin
      if (link.port_c_box_select) begin  // [RL7]
        // a full box drops the write unseen
        if (st_ff.full2_n) begin  // [RL14]
          nxt_st.mail2   = link.c_data;
          nxt_st.full2_n = 1'b0;  // [RL13]
        end
      end else begin
        nxt_st.q2_wr    = 1'b1;
        nxt_st.q2_wdata = link.c_data;
      end
    end

    // queue resets override any access in the same cycle
    // boxes keep their contents; a racing box write is dropped
    // so that flag and contents agree
    if (q1_rst) begin
      nxt_st.full1_n = mbx_pkg::FULL_N_RST;  // [RL12]
      nxt_st.b_out   = '0;
      nxt_st.q1_wr   = 1'b0;
      nxt_st.q1_rd   = 1'b0;
      nxt_st.mail1   = st_ff.mail1;
    end
    if (q2_rst) begin
      nxt_st.full2_n = mbx_pkg::FULL_N_RST;  // [RL16]
      nxt_st.a_out   = '0;
      nxt_st.q2_wr   = 1'b0;
      nxt_st.q2_rd   = 1'b0;
      // master reset of queue 2 comes with port C box select held high
      nxt_st.mail2   = st_ff.mail2;  // [RL8]
    end
  end

  // boxes clear only on srst_i
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff         <= '0;
      st_ff.full1_n <= mbx_pkg::FULL_N_RST;
      st_ff.full2_n <= mbx_pkg::FULL_N_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // link pins
  assign link.a_dev_data     = st_ff.a_out;
  assign link.a_dev_oe       = st_ff.a_oe;
  assign link.port_b_bus     = st_ff.b_out;
  assign link.b_oe           = st_ff.b_oe;
  assign link.box_one_full_n = st_ff.full1_n;
  assign link.box_two_full_n = st_ff.full2_n;

  // queue side pins
  assign q1_wr_o       = st_ff.q1_wr;
  assign q1_wdata_o    = st_ff.q1_wdata;
  assign q1_rd_o       = st_ff.q1_rd;
  assign q1_clear_o    = st_ff.q1_clr;
  assign q2_wr_o       = st_ff.q2_wr;
  assign q2_wdata_o    = st_ff.q2_wdata;
  assign q2_rd_o       = st_ff.q2_rd;
  assign q2_clear_o    = st_ff.q2_clr;
  assign loop_active_o = st_ff.loop_act;

endmodule

// [hdl/mbx_host.sv]
// Purpose: controller end driving ports A, B and C from software commands
// Assumes: device answers reads one cycle after the request
// Notes:   one command per write, no queueing of commands
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module mbx_host (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  // software port
  input  wire logic [mbx_pkg::AW-1:0]  addr_i,
  input  wire logic [mbx_pkg::DW-1:0]  wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic [mbx_pkg::DW-1:0]       rdata_o,
  output logic                         irq_o,
  // link
  mbx_link_if.host                     link
);

  typedef struct packed {
    logic [3:0]                ctrl;
    logic [mbx_pkg::A_W-1:0]   wdat;
    logic                      gate;
    logic                      a_wr;
    logic                      a_box;
    logic                      a_oe;
    logic                      b_rd;
    logic                      b_box;
    logic                      c_wr;
    logic                      c_box;
    logic                      pend_a;
    logic                      pend_b;
    logic [mbx_pkg::A_W-1:0]   a_rdat;
    logic [mbx_pkg::BC_W-1:0]  b_rdat;
    logic [mbx_pkg::IRQ_N-1:0] ist;
    logic [mbx_pkg::IRQ_N-1:0] imsk;
    logic                      f1_d;
    logic                      f2_d;
    logic [mbx_pkg::DW-1:0]    rdat;
    logic                      irq;
  } host_st_t;

  host_st_t st_ff;
  host_st_t nxt_st;

  mbx_pkg::op_t op;
  logic         is_cmd;
  logic         box;
  logic         loop_en;
  logic [mbx_pkg::IRQ_N-1:0] ev;

  assign op      = mbx_pkg::op_t'(wdata_i[2:0]);
  assign box     = wdata_i[mbx_pkg::CMD_BOX];
  assign is_cmd  = wr_i && (addr_i == mbx_pkg::OFS_CMD);
  assign loop_en = st_ff.ctrl[mbx_pkg::CTRL_LOOP];

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.a_wr   = 1'b0;
    nxt_st.a_oe   = 1'b0;
    nxt_st.b_rd   = 1'b0;
    nxt_st.c_wr   = 1'b0;
    nxt_st.pend_a = st_ff.gate && !st_ff.a_wr && !loop_en;
    nxt_st.pend_b = st_ff.b_rd;
    nxt_st.f1_d   = link.box_one_full_n;
    nxt_st.f2_d   = link.box_two_full_n;
    nxt_st.rdat   = '0;

    if (wr_i) begin
      unique case (addr_i)
        mbx_pkg::OFS_CTRL:    nxt_st.ctrl = wdata_i[3:0];
        mbx_pkg::OFS_DATA_LO: nxt_st.wdat[31:0] = wdata_i;
        mbx_pkg::OFS_DATA_HI: nxt_st.wdat[mbx_pkg::A_W-1:32] = wdata_i[mbx_pkg::A_W-33:0];
        mbx_pkg::OFS_IRQ_MSK: nxt_st.imsk = wdata_i[mbx_pkg::IRQ_N-1:0];
        default: ;
      endcase
    end

    // gate falls with the select pin, so leaving loopback is no port A read
    nxt_st.gate = nxt_st.ctrl[mbx_pkg::CTRL_LOOP];  // [RL2]

    // port A commands are dropped while loopback owns the port
    if (is_cmd) begin
      unique case (op)
        mbx_pkg::OP_A_WR: if (!loop_en) begin
          nxt_st.gate  = 1'b1;
          nxt_st.a_wr  = 1'b1;
          nxt_st.a_oe  = 1'b1;
          nxt_st.a_box = box;  // [RL3]
        end
        mbx_pkg::OP_A_RD: if (!loop_en) begin
          nxt_st.gate  = 1'b1;
          nxt_st.a_box = box;  // [RL3]
        end
        mbx_pkg::OP_B_RD: begin
          nxt_st.b_rd  = 1'b1;
          nxt_st.b_box = box;  // [RL5]
        end
        mbx_pkg::OP_C_WR: begin
          nxt_st.c_wr  = 1'b1;
          nxt_st.c_box = box;  // [RL7]
        end
        default: ;
      endcase
    end

    // box select on port C must stand high all through master reset
    if (nxt_st.ctrl[mbx_pkg::CTRL_MRS]) begin
      nxt_st.c_box = 1'b1;  // [RL8]
      nxt_st.c_wr  = 1'b0;
    end

    if (st_ff.pend_a) begin
      nxt_st.a_rdat = link.port_a_bus;
    end
    if (st_ff.pend_b) begin
      nxt_st.b_rdat = link.port_b_bus;
    end

    ev[mbx_pkg::IRQ_MB1]  = st_ff.f1_d && !link.box_one_full_n;
    ev[mbx_pkg::IRQ_MB2]  = st_ff.f2_d && !link.box_two_full_n;
    ev[mbx_pkg::IRQ_RDAT] = st_ff.pend_a || st_ff.pend_b;
    // a new event wins over a clear in the same cycle
    if (wr_i && addr_i == mbx_pkg::OFS_IRQ_ST) begin
      nxt_st.ist = st_ff.ist & ~wdata_i[mbx_pkg::IRQ_N-1:0];
    end
    nxt_st.ist = nxt_st.ist | ev;
    nxt_st.irq = |(nxt_st.ist & nxt_st.imsk);

    if (rd_i) begin
      unique case (addr_i)
        mbx_pkg::OFS_CTRL:    nxt_st.rdat = {28'h0000000, st_ff.ctrl};
        mbx_pkg::OFS_DATA_LO: nxt_st.rdat = st_ff.wdat[31:0];
        mbx_pkg::OFS_DATA_HI: nxt_st.rdat = {28'h0000000, st_ff.wdat[mbx_pkg::A_W-1:32]};
        mbx_pkg::OFS_FLAGS:   nxt_st.rdat = {30'h00000000, link.box_two_full_n, link.box_one_full_n};
        mbx_pkg::OFS_ARD_LO:  nxt_st.rdat = st_ff.a_rdat[31:0];
        mbx_pkg::OFS_ARD_HI:  nxt_st.rdat = {28'h0000000, st_ff.a_rdat[mbx_pkg::A_W-1:32]};
        mbx_pkg::OFS_BRD:     nxt_st.rdat = {14'h0000, st_ff.b_rdat};
        mbx_pkg::OFS_IRQ_ST:  nxt_st.rdat = {29'h00000000, st_ff.ist};
        mbx_pkg::OFS_IRQ_MSK: nxt_st.rdat = {29'h00000000, st_ff.imsk};
        default:              nxt_st.rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
      st_ff.f1_d <= mbx_pkg::FULL_N_RST;
      st_ff.f2_d <= mbx_pkg::FULL_N_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdat;
  assign irq_o   = st_ff.irq;

  assign link.port_a_transfer_gate      = st_ff.gate;
  assign link.a_write                   = st_ff.a_wr;
  assign link.port_a_box_select         = st_ff.a_box;
  assign link.loop_sel_n                = !loop_en;  // [RL2]
  assign link.a_host_data               = st_ff.wdat;
  assign link.a_host_oe                 = st_ff.a_oe;
  assign link.b_read                    = st_ff.b_rd;
  assign link.port_b_box_select         = st_ff.b_box;
  assign link.c_write                   = st_ff.c_wr;
  assign link.port_c_box_select         = st_ff.c_box;
  assign link.c_data                    = st_ff.wdat[mbx_pkg::BC_W-1:0];
  assign link.queue_one_master_reset_n  = !st_ff.ctrl[mbx_pkg::CTRL_MRS];
  assign link.queue_two_master_reset_n  = !st_ff.ctrl[mbx_pkg::CTRL_MRS];
  assign link.queue_one_partial_reset_n = !st_ff.ctrl[mbx_pkg::CTRL_QUEUE_ONE_PARTIAL_RESET_N];
  assign link.queue_two_partial_reset_n = !st_ff.ctrl[mbx_pkg::CTRL_QUEUE_TWO_PARTIAL_RESET_N];

endmodule

// [dv/mbx_link_assertions.sv]
// Purpose: flag and mailbox data checks on the link between both ends
// Assumes: one clock, synchronous active high reset
// Notes:   a shadow copy follows accepted box writes, boxes survive queue resets
`timescale 1ns/100ps
module mbx_link_assertions (
  // clock and reset
  input wire logic                     clk_i,
  input wire logic                     srst_i,
  // port A
  input wire logic                     port_a_transfer_gate,
  input wire logic                     a_write,
  input wire logic                     port_a_box_select,
  input wire logic                     loop_sel_n,
  input wire logic [mbx_pkg::A_W-1:0]  port_a_bus,
  input wire logic                     a_dev_oe,
  // ports B and C
  input wire logic                     b_read,
  input wire logic                     port_b_box_select,
  input wire logic [mbx_pkg::BC_W-1:0] port_b_bus,
  input wire logic                     b_oe,
  input wire logic                     c_write,
  input wire logic                     port_c_box_select,
  input wire logic [mbx_pkg::BC_W-1:0] c_data,
  // flags and queue resets
  input wire logic                     box_one_full_n,
  input wire logic                     box_two_full_n,
  input wire logic                     queue_one_master_reset_n,
  input wire logic                     queue_two_master_reset_n,
  input wire logic                     queue_one_partial_reset_n,
  input wire logic                     queue_two_partial_reset_n
);
  typedef struct packed {
    logic [mbx_pkg::BC_W-1:0] mail1;
    logic [mbx_pkg::BC_W-1:0] mail2;
  } shadow_t;
  shadow_t st_ff;
  shadow_t nxt_st;
  logic    rst1, rst2, acc_a, wr1, wr2, rd1, rd2;

  assign rst1  = !queue_one_master_reset_n || !queue_one_partial_reset_n;
  assign rst2  = !queue_two_master_reset_n || !queue_two_partial_reset_n;
  // a gated cycle with loopback selected is no port A access
  assign acc_a = port_a_transfer_gate && loop_sel_n;
  assign wr1   = acc_a && a_write && port_a_box_select && box_one_full_n && !rst1;
  assign wr2   = c_write && port_c_box_select && box_two_full_n && !rst2;
  assign rd1   = b_read && port_b_box_select && !rst1;
  assign rd2   = acc_a && !a_write && port_a_box_select && !rst2;

  always_comb begin
    nxt_st = st_ff;
    if (wr1 && !srst_i) begin
      nxt_st.mail1 = port_a_bus[mbx_pkg::BC_W-1:0];
    end
    if (wr2 && !srst_i) begin
      nxt_st.mail2 = c_data;
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  fill_one_a: assert property (wr1 |=> !box_one_full_n) else $error("flag one not lowered");
  keep_one_a: assert property (!box_one_full_n && !rd1 && !rst1 |=> !box_one_full_n) else $error("flag one rose");
  take_one_a: assert property (rd1 && !box_one_full_n |=> box_one_full_n) else $error("flag one stuck");
  clr_one_a: assert property (rst1 |=> box_one_full_n) else $error("flag one after reset");
  fill_two_a: assert property (wr2 |=> !box_two_full_n) else $error("flag two not lowered");
  keep_two_a: assert property (!box_two_full_n && !rd2 && !rst2 |=> $stable(box_two_full_n)) else $error("flag two rose");
  take_two_a: assert property (rd2 && !box_two_full_n |-> ##1 box_two_full_n) else $error("flag two stuck");
  clr_two_a: assert property (rst2 |=> box_two_full_n) else $error("flag two after reset");
  data_b_a: assert property (rd1 && !box_one_full_n |=> b_oe && port_b_bus == st_ff.mail1) else $error("mail one data");
  data_a_a: assert property (rd2 && !box_two_full_n |=> a_dev_oe && port_a_bus == {18'h0, st_ff.mail2}) else $error("mail two");
  mrs_box_c_a: assert property (!queue_one_master_reset_n |-> port_c_box_select) else $error("box select low in reset");

  cover property (wr1);
  cover property (wr2);
  cover property (port_a_transfer_gate && !loop_sel_n);
endmodule

// [dv/fifo_mailbox_bypass_loopback_tb_top.sv]
// Purpose: drives the software port of the controller and checks both link ends
// Assumes: a command reaches the device and returns within four cycles
// Notes:   queue side data are fixed words from the bench
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp); \
  end \
end
module fifo_mailbox_bypass_loopback_tb_top;
  localparam logic [35:0] Q2_WORD = 36'hA_5C3C_96E1;
  localparam logic [17:0] Q1_WORD = 18'h2_C3A5;
  localparam logic [31:0] W1      = 32'hDEAD_BEEF;
  localparam logic [31:0] W2      = 32'h1234_5678;
  logic                     clk_i      = 1'b0;
  logic                     srst_i     = 1'b1;
  logic [mbx_pkg::AW-1:0]   addr_i     = 8'h00;
  logic [mbx_pkg::DW-1:0]   wdata_i    = 32'h0;
  logic                     wr_i       = 1'b0;
  logic                     rd_i       = 1'b0;
  logic [mbx_pkg::A_W-1:0]  q2_rdata_i = Q2_WORD;
  logic [mbx_pkg::BC_W-1:0] q1_rdata_i = Q1_WORD;
  logic [mbx_pkg::DW-1:0]   rdata_o;
  logic                     irq_o, q1_wr_o, q2_wr_o, loop_active_o, q1_rd_o, q2_rd_o, q1_clear_o, q2_clear_o;
  logic [mbx_pkg::A_W-1:0]  q1_wdata_o, q1_seen;
  logic [mbx_pkg::BC_W-1:0] q2_wdata_o, q2_seen;
  int                       err_total  = 0;
  int                       num_checks = 0;
  int                       q1_rds     = 0;
  int                       q2_rds     = 0;

  always #25 clk_i = ~clk_i;

  mbx_link_if link_if ();
  mbx_device mbx_device_i (
    .clk_i(clk_i), .srst_i(srst_i), .link(link_if), .q1_wr_o(q1_wr_o), .q1_wdata_o(q1_wdata_o), .q1_rd_o(q1_rd_o),
    .q1_rdata_i(q1_rdata_i), .q1_clear_o(q1_clear_o), .q2_wr_o(q2_wr_o), .q2_wdata_o(q2_wdata_o), .q2_rd_o(q2_rd_o),
    .q2_rdata_i(q2_rdata_i), .q2_clear_o(q2_clear_o), .loop_active_o(loop_active_o)
  );
  mbx_host mbx_host_i (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .link(link_if)
  );
  mbx_link_assertions mbx_link_assertions_i (
    .clk_i(clk_i), .srst_i(srst_i), .port_a_transfer_gate(link_if.port_a_transfer_gate),
    .a_write(link_if.a_write), .port_a_box_select(link_if.port_a_box_select), .loop_sel_n(link_if.loop_sel_n),
    .port_a_bus(link_if.port_a_bus), .a_dev_oe(link_if.a_dev_oe), .b_read(link_if.b_read),
    .port_b_box_select(link_if.port_b_box_select), .port_b_bus(link_if.port_b_bus), .b_oe(link_if.b_oe),
    .c_write(link_if.c_write), .port_c_box_select(link_if.port_c_box_select), .c_data(link_if.c_data),
    .box_one_full_n(link_if.box_one_full_n), .box_two_full_n(link_if.box_two_full_n),
    .queue_one_master_reset_n(link_if.queue_one_master_reset_n),
    .queue_two_master_reset_n(link_if.queue_two_master_reset_n),
    .queue_one_partial_reset_n(link_if.queue_one_partial_reset_n),
    .queue_two_partial_reset_n(link_if.queue_two_partial_reset_n)
  );

  // command queue writes are single pulses, loopback writes queue 1 every cycle, so keep the last word for later compares
  always @(posedge clk_i) begin
    if (q1_wr_o) begin
      q1_seen <= q1_wdata_o;
    end
    if (q2_wr_o) begin
      q2_seen <= q2_wdata_o;
    end
    q1_rds <= q1_rds + q1_rd_o;
    q2_rds <= q2_rds + q2_rd_o;
  end

  // tasks end just after an edge so that checks see settled outputs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e, m)
  endtask

  task automatic cmd(input logic [2:0] op, input logic box);
    wr(mbx_pkg::OFS_CMD, {28'h0, box, op});
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic t_box_one();
    wr(mbx_pkg::OFS_DATA_LO, W1);
    cmd(3'h1, 1'b1);
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h2, "flag one");
    wr(mbx_pkg::OFS_DATA_LO, W2);
    cmd(3'h1, 1'b1);
    cmd(3'h3, 1'b1);
    expect_reg(mbx_pkg::OFS_BRD, {14'h0, W1[17:0]}, "mail one");
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h3, "flag one read");
    cmd(3'h3, 1'b1);
    expect_reg(mbx_pkg::OFS_BRD, {14'h0, W1[17:0]}, "mail one again");
  endtask

  task automatic t_box_two();
    wr(mbx_pkg::OFS_DATA_LO, W2);
    cmd(3'h4, 1'b1);
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h1, "flag two");
    wr(mbx_pkg::OFS_DATA_LO, W1);
    cmd(3'h4, 1'b1);
    cmd(3'h2, 1'b1);
    expect_reg(mbx_pkg::OFS_ARD_LO, {14'h0, W2[17:0]}, "mail two");
    expect_reg(mbx_pkg::OFS_ARD_HI, 32'h0, "mail two high");
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h3, "flag two read");
  endtask

  task automatic t_queues();
    wr(mbx_pkg::OFS_DATA_HI, 32'h0000_000A);
    cmd(3'h3, 1'b0);
    expect_reg(mbx_pkg::OFS_BRD, {14'h0, Q1_WORD}, "queue one out");
    `CHK(q1_rds, 1, "queue one read")
    cmd(3'h2, 1'b0);
    `CHK(q2_rds, 1, "queue two read")
    expect_reg(mbx_pkg::OFS_ARD_LO, Q2_WORD[31:0], "queue two low");
    expect_reg(mbx_pkg::OFS_ARD_HI, {28'h0, Q2_WORD[35:32]}, "queue two high");
    cmd(3'h4, 1'b0);
    `CHK(q2_seen, W1[17:0], "queue two in")
    cmd(3'h1, 1'b0);
    `CHK(q1_seen, {4'hA, W1}, "queue one in")
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h3, "flags kept");
  endtask

  task automatic t_resets();
    cmd(3'h1, 1'b1);
    cmd(3'h4, 1'b1);
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h0, "both full");
    wr(mbx_pkg::OFS_CTRL, 32'h4);
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h1, "partial one");
    `CHK({q1_clear_o, q2_clear_o}, 2'h2, "clear one")
    wr(mbx_pkg::OFS_CTRL, 32'h8);
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h3, "partial two");
    `CHK({q1_clear_o, q2_clear_o}, 2'h1, "clear two")
    wr(mbx_pkg::OFS_CTRL, 32'h0);
    cmd(3'h1, 1'b1);
    cmd(3'h4, 1'b1);
    wr(mbx_pkg::OFS_CTRL, 32'h2);
    cmd(3'h4, 1'b1);
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h3, "master reset");
    wr(mbx_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic t_irq();
    wr(mbx_pkg::OFS_IRQ_ST, 32'h7);
    wr(mbx_pkg::OFS_IRQ_MSK, 32'h1);
    `CHK(irq_o, 1'b0, "irq idle")
    cmd(3'h1, 1'b1);
    `CHK(irq_o, 1'b1, "irq raised")
    wr(mbx_pkg::OFS_IRQ_MSK, 32'h0);
    `CHK(irq_o, 1'b0, "irq masked")
    wr(mbx_pkg::OFS_IRQ_MSK, 32'h1);
    wr(mbx_pkg::OFS_IRQ_ST, 32'h1);
    `CHK(irq_o, 1'b0, "irq cleared")
    cmd(3'h3, 1'b1);
    wr(8'hF0, 32'hFFFF_FFFF);
    expect_reg(8'hF0, 32'h0, "unmapped");
  endtask

  task automatic t_loop();
    wr(mbx_pkg::OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(loop_active_o, 1'b1, "loop on")
    `CHK(q1_seen, Q2_WORD, "loop word")
    wr(mbx_pkg::OFS_CTRL, 32'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    expect_reg(mbx_pkg::OFS_FLAGS, 32'h3, "flags at reset");
    `CHK(irq_o, 1'b0, "irq at reset")
    t_box_one();
    t_box_two();
    t_queues();
    t_resets();
    t_irq();
    t_loop();
    end_of_test();
  end
endmodule
